// ### access_jitter_defines.svh
// access and jitter control register map, field positions, reset values
// assumes an 8-bit parallel register port with 5-bit word addresses
`ifndef ACCESS_JITTER_DEFINES_SVH
`define ACCESS_JITTER_DEFINES_SVH

`define ACW_OFFSET 5'h13
`define JAC_OFFSET 5'h18

`define ACW_ALARM_SRC_BIT 2
`define ACW_TEST_SEQ_BIT 1
`define ACW_FP_FMT_BIT 0
`define ACW_USED_MASK 8'h07
`define ACW_RESET 8'h00

`define JAC_SELECT_BIT 7
`define JAC_DIR_BIT 6
`define JAC_CENTRE_BIT 5
`define JAC_DEPTH_HI 4
`define JAC_DEPTH_LO 2
`define JAC_CLEAR_BIT 1
`define JAC_USED_MASK 8'hfe
`define JAC_RESET 8'h00

`define DEPTH_STEP_WORDS 8'h10
`define DEPTH_MAX_CODE 3'h3

`endif

// ### access_jitter_pkg.sv
// types shared by the access and jitter control block
// assumes nothing beyond a SystemVerilog compiler
package access_jitter_pkg;
  typedef enum logic {
    SEQ_PRBS,
    SEQ_MILLIWATT
  } test_seq_e;
  typedef enum logic {
    FP_NATIVE,
    FP_GCI
  } fp_fmt_e;
  typedef enum logic {
    JA_RX,
    JA_TX
  } ja_dir_e;
endpackage : access_jitter_pkg

// ### depth_decode.sv
// small registered decoder from the depth code to a fifo depth in words
// assumes same-clock inputs from the register bank
`timescale 1ns/1ps
`default_nettype none
`include "access_jitter_defines.svh"
module depth_decode (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [2:0] code_i,
  output logic [7:0] depth_words_o
);
  // codes above the table saturate at the largest documented depth
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      depth_words_o <= `DEPTH_STEP_WORDS;
    end else if (code_i > `DEPTH_MAX_CODE) begin
      depth_words_o <= 8'(`DEPTH_STEP_WORDS * 8'(`DEPTH_MAX_CODE + 3'h1));
    end else begin
      depth_words_o <= 8'(`DEPTH_STEP_WORDS * 8'(code_i + 3'h1));
    end
  end
endmodule : depth_decode
`default_nettype wire

// ### access_jitter_ctrl.sv
// access control word and jitter attenuator control word register bank
// assumes an 8-bit parallel port on ref_clk_i; alarm inputs from pins
// the host may write both words back to back; no wait states are added
// limitation: depth codes 100 to 111 saturate at 64 words
//
// What this block does
// - with the alarm source bit set, the loss alarm pin follows loss of signal only.
// - with it clear, the pin rises on loss of signal or when frame sync is lost.
// - test sequence bit one selects the digital milliwatt for timeslot tests.
// - test sequence bit zero selects the 2^15-1 pseudo-random pattern.
// - writing the test sequence bit to one resets the pattern generator.
// - bit 0 picks GCI (one) or native (zero) backplane frame pulse format.
// - attenuator select one inserts the attenuator, zero disables it.
// - direction one places the attenuator on transmit, zero on receive.
// - each toggle of the centre bit recentres the fifo read pointer.
// - depth codes 000 to 011 give 16, 32, 48 and 64 words.
// - the clear bit resets attenuator, fifo and status, leaving data bits.
`timescale 1ns/1ps
`default_nettype none
`include "access_jitter_defines.svh"
module access_jitter_ctrl (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [4:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic line_signal_loss_status_i,
  input wire logic frame_sync_i,
  output logic loss_alarm_pin_o,
  output logic tx_use_milliwatt_o,
  output logic rx_use_milliwatt_o,
  output logic prbs_reset_o,
  output logic frame_pulse_gci_o,
  output logic attenuator_tx_enable_o,
  output logic attenuator_rx_enable_o,
  output logic attenuator_centre_o,
  output logic [7:0] attenuator_depth_words_o,
  output logic attenuator_clear_o
);
  logic [7:0] access_control_word;
  logic [7:0] jitter_attenuator_control;
  logic [2:0] los_sync;
  logic [2:0] fs_sync;
  logic los_stable;
  logic fs_stable;
  logic centre_prev;
  logic write_acw;
  logic write_jac;
  logic use_milliwatt;
  logic [7:0] next_rdata;
  access_jitter_pkg::test_seq_e test_seq;
  access_jitter_pkg::ja_dir_e ja_dir;

  // address match, shared by the write strobes and the read mux
  function automatic logic addr_hit(
    logic [4:0] a,
    logic [4:0] o
  );
    return a == o;
  endfunction : addr_hit

  assign write_acw = wr_i && addr_hit(addr_i, `ACW_OFFSET);
  assign write_jac = wr_i && addr_hit(addr_i, `JAC_OFFSET);
  assign test_seq = access_jitter_pkg::test_seq_e'(
    access_control_word[`ACW_TEST_SEQ_BIT]);
  assign ja_dir = access_jitter_pkg::ja_dir_e'(
    jitter_attenuator_control[`JAC_DIR_BIT]);
  // one decode feeds both timeslot test directions
  assign use_milliwatt = (test_seq == access_jitter_pkg::SEQ_MILLIWATT);

  // access control word; only the three defined bits are stored
  // bits 7 to 3 are dropped at the door so a read can never show them
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      access_control_word <= `ACW_RESET;
    end else if (write_acw) begin
      access_control_word <= wdata_i & `ACW_USED_MASK;
    end
  end

  // jitter control word; bit 0 is unused and reads zero
  // clear is stored like the rest, so a read shows it still set
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      jitter_attenuator_control <= `JAC_RESET;
    end else if (write_jac) begin
      jitter_attenuator_control <= wdata_i & `JAC_USED_MASK;
    end
  end

  // read mux kept combinational so the output stage is a plain load
  always_comb begin
    next_rdata = 8'h00;
    if (addr_hit(addr_i, `ACW_OFFSET)) begin
      next_rdata = access_control_word;
    end else if (addr_hit(addr_i, `JAC_OFFSET)) begin
      next_rdata = jitter_attenuator_control;
    end
  end

  // registered read data; unmapped addresses read zero
  // a write and a read on one edge return the old contents
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end
  end

  // status pins come from outside; three stages, change once 2nd and 3rd agree
  // a one-edge glitch never reaches the alarm; the price is five edges of lag
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      los_sync <= 3'h0;
      fs_sync <= 3'h7;
      los_stable <= 1'b0;
      fs_stable <= 1'b1;
    end else begin
      los_sync <= {los_sync[1:0], line_signal_loss_status_i};
      fs_sync <= {fs_sync[1:0], frame_sync_i};
      if (los_sync[1] == los_sync[2]) begin
        los_stable <= los_sync[2];
      end
      if (fs_sync[1] == fs_sync[2]) begin
        fs_stable <= fs_sync[2];
      end
    end
  end

  // loss alarm source selection
  // a change of source takes effect on the next edge, even mid-alarm
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loss_alarm_pin_o <= 1'b0;
    end else if (access_control_word[`ACW_ALARM_SRC_BIT]) begin
      loss_alarm_pin_o <= los_stable;
    end else begin
      loss_alarm_pin_o <= los_stable || !fs_stable;
    end
  end

  // test sequence choice for both timeslot test directions
  // each timeslot's own test enable decides whether the choice is used
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_use_milliwatt_o <= 1'b0;
      rx_use_milliwatt_o <= 1'b0;
    end else begin
      tx_use_milliwatt_o <= use_milliwatt;
      rx_use_milliwatt_o <= use_milliwatt;
    end
  end

  // one-cycle prbs reset on every write of a one, even if already one
  // a write of zero never pulses, so leaving milliwatt mode is quiet
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prbs_reset_o <= 1'b0;
    end else begin
      prbs_reset_o <= write_acw && wdata_i[`ACW_TEST_SEQ_BIT];
    end
  end

  // frame pulse format, shared by transmit and receive
  // one bit serves both directions; there is no separate choice per side
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frame_pulse_gci_o <= 1'b0;
    end else begin
      frame_pulse_gci_o <= access_control_word[`ACW_FP_FMT_BIT];
    end
  end

  // attenuator placement; never both paths at once
  // the direction bit alone enables nothing while select is zero
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      attenuator_tx_enable_o <= 1'b0;
      attenuator_rx_enable_o <= 1'b0;
    end else begin
      attenuator_tx_enable_o <= jitter_attenuator_control[`JAC_SELECT_BIT]
        && (ja_dir == access_jitter_pkg::JA_TX);
      attenuator_rx_enable_o <= jitter_attenuator_control[`JAC_SELECT_BIT]
        && (ja_dir == access_jitter_pkg::JA_RX);
    end
  end

  // centre pulse on either edge of the stored bit, not on its level
  // rewriting bit 5 with its old value leaves the read pointer alone
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      centre_prev <= 1'b0;
      attenuator_centre_o <= 1'b0;
    end else begin
      centre_prev <= jitter_attenuator_control[`JAC_CENTRE_BIT];
      attenuator_centre_o <= centre_prev
        ^ jitter_attenuator_control[`JAC_CENTRE_BIT];
    end
  end

  // clear is a level held while the bit is one; data memory is untouched
  // software must write the bit back to zero before the attenuator runs
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      attenuator_clear_o <= 1'b0;
    end else begin
      attenuator_clear_o <= jitter_attenuator_control[`JAC_CLEAR_BIT];
    end
  end

  // depth decode in its own registered stage
  // its flop stands in for an output flop, so depth has no extra lag
  depth_decode u_depth (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .code_i(jitter_attenuator_control[`JAC_DEPTH_HI:`JAC_DEPTH_LO]),
    .depth_words_o(attenuator_depth_words_o)
  );
endmodule : access_jitter_ctrl
`default_nettype wire

// ### access_jitter_checker.sv
// assertions on the access and jitter register bank ports
// assumes binding onto access_jitter_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "access_jitter_defines.svh"
module access_jitter_checker (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [4:0] addr_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic line_signal_loss_status_i,
  input wire logic frame_sync_i,
  input wire logic loss_alarm_pin_o,
  input wire logic tx_use_milliwatt_o,
  input wire logic prbs_reset_o,
  input wire logic frame_pulse_gci_o,
  input wire logic attenuator_tx_enable_o,
  input wire logic attenuator_rx_enable_o,
  input wire logic attenuator_centre_o,
  input wire logic [7:0] attenuator_depth_words_o,
  input wire logic attenuator_clear_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // write strobes per register; effects land two edges later, except the prbs reset, which lands one edge later
  wire acw = wr_i && addr_i == `ACW_OFFSET;
  wire jw = wr_i && addr_i == `JAC_OFFSET;
  logic centre_seen;
  // mirror of the stored centre bit, rebuilt from writes seen on the port
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      centre_seen <= 1'b0;
    end else if (jw) begin
      centre_seen <= wdata_i[5];
    end
  end
  sequence quiet_line;
    !line_signal_loss_status_i && frame_sync_i;
  endsequence
  property ja_place;
    logic [7:0] d;
    (jw, d = wdata_i) |-> ##2 attenuator_tx_enable_o == (d[7] & d[6])
      && attenuator_rx_enable_o == (d[7] & !d[6]) && attenuator_clear_o == d[1];
  endproperty
  // the decoder flop is the output flop, so depth keeps the common lag
  property depth_code;
    logic [2:0] c;
    (jw, c = wdata_i[4:2]) |-> ##2 attenuator_depth_words_o ==
      (c > 3'h3 ? 8'h40 : 8'h10 * (8'h01 + c));
  endproperty
  alarm_quiet_a: assert property (quiet_line [*6] |=> !loss_alarm_pin_o)
    else $error("alarm with no cause");
  alarm_raise_a: assert property (line_signal_loss_status_i [*6]
    |=> loss_alarm_pin_o) else $error("loss of signal missed");
  prbs_pulse_a: assert property (acw && wdata_i[1] |=> prbs_reset_o)
    else $error("no generator reset");
  seq_follow_a: assert property (acw |-> ##2
    tx_use_milliwatt_o == $past(wdata_i[1], 2)) else $error("bad sequence");
  gci_follow_a: assert property (acw |-> ##2
    frame_pulse_gci_o == $past(wdata_i[0], 2)) else $error("bad pulse format");
  ja_place_a: assert property (ja_place)
    else $error("bad attenuator placement");
  depth_code_a: assert property (depth_code)
    else $error("bad fifo depth");
  centre_cause_a: assert property (attenuator_centre_o |-> $past(jw, 2))
    else $error("centre pulse with no write");
  centre_toggle_a: assert property (jw && wdata_i[5] != centre_seen
    |-> ##2 attenuator_centre_o) else $error("toggle gave no centre pulse");
endmodule : access_jitter_checker
bind access_jitter_ctrl access_jitter_checker i_chk (
  .ref_clk_i(ref_clk_i),
  .arst_n_i(arst_n_i),
  .addr_i(addr_i),
  .wr_i(wr_i),
  .wdata_i(wdata_i),
  .line_signal_loss_status_i(line_signal_loss_status_i),
  .frame_sync_i(frame_sync_i),
  .loss_alarm_pin_o(loss_alarm_pin_o),
  .tx_use_milliwatt_o(tx_use_milliwatt_o),
  .prbs_reset_o(prbs_reset_o),
  .frame_pulse_gci_o(frame_pulse_gci_o),
  .attenuator_tx_enable_o(attenuator_tx_enable_o),
  .attenuator_rx_enable_o(attenuator_rx_enable_o),
  .attenuator_centre_o(attenuator_centre_o),
  .attenuator_depth_words_o(attenuator_depth_words_o),
  .attenuator_clear_o(attenuator_clear_o)
);
`default_nettype wire

// ### host_model.sv
// host processor model on the parallel register port
// assumes one calling process; idle bus shows inverted last values
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  output logic [4:0] addr_o = 5'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [7:0] wdata_o = 8'h00
);
  task wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    {addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
    @(posedge ref_clk_i);
    {addr_o, wdata_o, wr_o} <= {~a, ~d, 1'b0};
  endtask : wr_reg
  // data is taken one edge late since it holds until the next read
  task rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    {addr_o, rd_o} <= {a, 1'b1};
    @(posedge ref_clk_i);
    {addr_o, rd_o} <= {~a, 1'b0};
    @(posedge ref_clk_i);
    #1 d = rdata_i;
  endtask : rd_reg
endmodule : host_model
`default_nettype wire

// ### e1_access_and_jitter_control_tb.sv
// self-checking bench for the access and jitter register bank
// assumes host_model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module e1_access_and_jitter_control_tb;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic line_signal_loss_status_i = 1'b0;
  logic frame_sync_i = 1'b1;
  logic [4:0] addr_i;
  logic wr_i, rd_i, loss_alarm_pin_o, tx_use_milliwatt_o, rx_use_milliwatt_o;
  logic prbs_reset_o, frame_pulse_gci_o, attenuator_tx_enable_o;
  logic attenuator_rx_enable_o, attenuator_centre_o, attenuator_clear_o;
  logic [7:0] wdata_i, rdata_o, attenuator_depth_words_o, w, d, prev;
  int failures = 0, n_checks = 0, cyc = 0, i;
  always #10 ref_clk_i = ~ref_clk_i;
  host_model i_host (.ref_clk_i(ref_clk_i), .rdata_i(rdata_o), .addr_o(addr_i),
    .wr_o(wr_i), .rd_o(rd_i), .wdata_o(wdata_i));
  access_jitter_ctrl i_dut (.*);
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [7:0] dep(input logic [2:0] c);
    return c > 3'h3 ? 8'h40 : 8'h10 * (8'h01 + c);
  endfunction : dep
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    void'($urandom(6));
    repeat (16) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    #1 chk("depth", 8'h10, attenuator_depth_words_o);
    i_host.rd_reg(5'h14, d);
    chk("unmapped", 8'h00, d);
    $display("reset test done");
    // every low pattern, with random junk in the unused bits
    for (i = 0; i < 8; i++) begin
      w = 8'($urandom) & 8'hf8 | 8'(i);
      i_host.wr_reg(5'h13, w);
      #1 chk("prbs", 8'(w[1]), 8'(prbs_reset_o));
      @(posedge ref_clk_i);
      #1 chk("tx seq", 8'(w[1]), 8'(tx_use_milliwatt_o));
      chk("rx seq", 8'(w[1]), 8'(rx_use_milliwatt_o));
      chk("gci", 8'(w[0]), 8'(frame_pulse_gci_o));
      i_host.rd_reg(5'h13, d);
      chk("acw", w & 8'h07, d);
      i_host.rd_reg(5'h14, d);
      chk("unmapped", 8'h00, d);
    end
    $display("access word test done");
    for (i = 0; i < 8; i++) begin
      i_host.wr_reg(5'h13, 8'(i[2]) << 2);
      line_signal_loss_status_i <= i[0];
      frame_sync_i <= i[1];
      repeat (6) @(posedge ref_clk_i);
      #1 chk("alarm", 8'(i[0] | !(i[2] | i[1])), 8'(loss_alarm_pin_o));
    end
    $display("alarm test done");
    prev = 8'h00;
    for (i = 0; i < 16; i++) begin
      w = 8'($urandom);
      w[5] = i[1];
      if (i < 8) w[4:2] = i[2:0];
      i_host.wr_reg(5'h18, w);
      @(posedge ref_clk_i);
      #1 chk("centre", 8'(w[5] ^ prev[5]), 8'(attenuator_centre_o));
      chk("tx ja", 8'(w[7] & w[6]), 8'(attenuator_tx_enable_o));
      chk("rx ja", 8'(w[7] & !w[6]), 8'(attenuator_rx_enable_o));
      chk("clear", 8'(w[1]), 8'(attenuator_clear_o));
      @(posedge ref_clk_i);
      #1 chk("depth", dep(w[4:2]), attenuator_depth_words_o);
      i_host.rd_reg(5'h18, d);
      chk("jac", w & 8'hfe, d);
      prev = w;
    end
    $display("jitter word test done");
    // second reset in mid-run, with the loss pin still high
    @(posedge ref_clk_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    #1 chk("reset alarm", 8'h00, 8'(loss_alarm_pin_o));
    chk("reset depth", 8'h10, attenuator_depth_words_o);
    chk("reset tx ja", 8'h00, 8'(attenuator_tx_enable_o));
    i_host.rd_reg(5'h18, d);
    chk("reset jac", 8'h00, d);
    $display("mid-run reset test done");
    close_out();
  end
endmodule : e1_access_and_jitter_control_tb
`default_nettype wire
